// [hdl/cdr_readback.sv]
// readback bank: boost code and detected configuration, bus address select
//
// Overview of operation
// - boost readback shows live 11-bit boost code in bits 10:0, upper bits zero.
// - configuration readback at 1Eh, 16 bits, read-only, zero until detection loads.
// - bits 14:12 give dimming frequency code, 152 Hz doubling to 19531 Hz.
// - bits 10:8 codes 0 to 4 mean six down to two separate strings.
// - layout codes 5, 6, 7 mean three groups, two groups, one tied string.
// - bits 5:3 give boost switching frequency code, 100 to 2222 kHz.
// - bits 2:0 give dimming mode; low two bits pick the dimming method.
// - bus address is 2Bh for mode codes 0 to 3, 2Ah for 4 to 7.
// - reserved bits 15, 11, 7 and 6 of configuration readback read zero.
// - six separate strings get dimming starts spread 60 degrees apart.
// - boost readback lives at 1Ch and resets to zero.
`timescale 1ns/1ps
module cdr_readback
    import cdr_pkg::*;
#(
    parameter int FAST_PERIOD_CYC = CDR_FAST_PERIOD_CYC
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // register port from the serial bus engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_ack,
    // adaptive boost loop
    input  wire logic [10:0] boost_voltage_code,
    // strap detection
    input  wire logic        detect_done,
    input  wire logic [2:0]  dimming_frequency_strap,
    input  wire logic [2:0]  string_layout_strap,
    input  wire logic [2:0]  switching_frequency_strap,
    input  wire logic [2:0]  mode_strap,
    // decoded settings
    output logic [6:0]       bus_address,
    output cdr_dim_mode_t    dimming_mode,
    output logic [2:0]       detected_string_layout,
    output logic [2:0]       detected_switching_frequency,
    output logic [5:0]       channel_start
);

    logic [2:0]  det_dim_freq;
    logic [2:0]  det_layout;
    logic [2:0]  det_sw_freq;
    logic [2:0]  det_mode;
    logic        detect_loaded;
    logic [10:0] boost_hold;
    logic [10:0] next_boost_hold;
    logic [15:0] next_reg_rdata;
    logic        next_reg_ack;
    logic [6:0]  next_bus_address;
    logic [15:0] config_word;
    logic [15:0] boost_word;
    logic        write_seen;

    // ========================================================================
    // decoding shared by the read path and the address select
    function automatic logic [15:0] cdr_pack_config(
        input logic [2:0] dim_freq,
        input logic [2:0] layout,
        input logic [2:0] sw_freq,
        input logic [2:0] mode
    );
        logic [15:0] word;
        word = 16'h0000;
        word[CDR_DIM_FREQ_LSB +: CDR_CODE_W] = dim_freq;
        word[CDR_LAYOUT_LSB +: CDR_CODE_W]   = layout;
        word[CDR_SW_FREQ_LSB +: CDR_CODE_W]  = sw_freq;
        word[CDR_MODE_LSB +: CDR_CODE_W]     = mode;
        return word & CDR_CONFIG_USED_MASK;
    endfunction

    function automatic logic [6:0] cdr_addr_of(input logic [2:0] mode);
        return mode[CDR_MODE_ADDR_BIT] ? CDR_BUS_ADDR_HIGH_MODES : CDR_BUS_ADDR_LOW_MODES;
    endfunction

    // ========================================================================
    // strap capture and phase spreading
    cdr_strap_capture u_capture
    (
        .sys_clk                      (sys_clk),
        .rst_b                        (rst_b),
        .detect_done                  (detect_done),
        .dimming_frequency_strap      (dimming_frequency_strap),
        .string_layout_strap          (string_layout_strap),
        .switching_frequency_strap    (switching_frequency_strap),
        .mode_strap                   (mode_strap),
        .detect_loaded                (detect_loaded),
        .detected_dimming_frequency   (det_dim_freq),
        .detected_string_layout       (det_layout),
        .detected_switching_frequency (det_sw_freq),
        .detected_mode                (det_mode)
    );

    // spreading only applies to six independent strings
    cdr_phase_spread #(
        .FAST_PERIOD_CYC (FAST_PERIOD_CYC)
    ) u_spread
    (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .run           (detect_loaded),
        .spread        (det_layout == CDR_LAYOUT_SIX_SEPARATE),
        .dim_freq_code (det_dim_freq),
        .channel_start (channel_start)
    );

    assign detected_string_layout       = det_layout;
    assign detected_switching_frequency = det_sw_freq;
    assign dimming_mode                 = cdr_dim_mode_t'(det_mode[1:0]);

    // ========================================================================
    // read words
    assign config_word = cdr_pack_config(det_dim_freq, det_layout, det_sw_freq, det_mode);
    assign boost_word  = {5'h00, boost_hold} & CDR_BOOST_USED_MASK;
    assign write_seen  = reg_wr && (reg_wdata != 16'h0000 || reg_wdata == 16'h0000);

    // ========================================================================
    // next values
    always_comb
    begin
        next_boost_hold  = boost_voltage_code;
        next_reg_ack     = reg_rd || write_seen;
        next_reg_rdata   = reg_rdata;
        next_bus_address = cdr_addr_of(det_mode);
        if (reg_rd)
        begin
            case (reg_addr)
                CDR_BOOST_OFFSET:  next_reg_rdata = boost_word;
                CDR_CONFIG_OFFSET: next_reg_rdata = config_word;
                default:           next_reg_rdata = CDR_UNMAPPED_VALUE;
            endcase
        end
    end

    // ========================================================================
    // registers; a write only returns an acknowledge, nothing is stored
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            boost_hold  <= CDR_REG_RESET[10:0];
            reg_rdata   <= CDR_REG_RESET;
            reg_ack     <= 1'b0;
            bus_address <= CDR_BUS_ADDR_LOW_MODES;
        end
        else
        begin
            boost_hold  <= next_boost_hold;
            reg_rdata   <= next_reg_rdata;
            reg_ack     <= next_reg_ack;
            bus_address <= next_bus_address;
        end
    end

    // ========================================================================
    // checks
    boost_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b) && reg_rd && reg_addr == CDR_BOOST_OFFSET ##1 rst_b |->
        reg_rdata == {5'h00, $past(boost_voltage_code, 2)})
        else $error("boost readback does not match loop code");

    boost_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == CDR_BOOST_OFFSET |-> reg_rdata[15:11] == 5'h00)
        else $error("boost readback upper bits not zero");

    config_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !detect_loaded && reg_rd && reg_addr == CDR_CONFIG_OFFSET |=> reg_rdata == 16'h0000)
        else $error("configuration readback nonzero before detection");

    config_fields_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd && reg_addr == CDR_CONFIG_OFFSET |=>
        reg_rdata[14:12] == $past(det_dim_freq) && reg_rdata[10:8] == $past(det_layout) &&
        reg_rdata[5:3] == $past(det_sw_freq) && reg_rdata[2:0] == $past(det_mode))
        else $error("configuration field placement wrong");

    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(reg_rd) && $past(reg_addr) == CDR_CONFIG_OFFSET |->
        reg_rdata[15] == 1'b0 && reg_rdata[11] == 1'b0 && reg_rdata[7:6] == 2'b00)
        else $error("reserved configuration bits not zero");

    bus_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        detect_loaded ##1 detect_loaded |->
        bus_address == ($past(det_mode[2]) ? 7'h2A : 7'h2B))
        else $error("bus address does not follow mode");

    write_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && !reg_rd ##1 !reg_rd && !reg_wr |=> reg_rdata == $past(reg_rdata, 2) && reg_ack == 1'b0)
        else $error("write disturbed readback");

    held_config_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        detect_loaded |=> $stable(config_word))
        else $error("configuration changed after detection");

    spread_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        detect_loaded && det_layout == CDR_LAYOUT_SIX_SEPARATE && channel_start != 6'h00 |->
        $onehot(channel_start))
        else $error("six-string starts not staggered");

    layout_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        detect_done && !detect_loaded |=>
        detected_string_layout == $past(string_layout_strap) &&
        dimming_mode == cdr_dim_mode_t'($past(mode_strap[1:0])))
        else $error("layout or mode not latched from straps");

    grouped_start_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        detect_loaded && det_layout != CDR_LAYOUT_SIX_SEPARATE && channel_start != 6'h00 |->
        channel_start == 6'h3F)
        else $error("grouped strings not started together");

endmodule

// [hdl/cdr_pkg.sv]
// shared constants and types for the configuration and boost readback bank
package cdr_pkg;

    // ========================================================================
    // register offsets and reset values
    localparam logic [7:0]  CDR_BOOST_OFFSET   = 8'h1C;
    localparam logic [7:0]  CDR_CONFIG_OFFSET  = 8'h1E;
    localparam logic [15:0] CDR_REG_RESET      = 16'h0000;
    localparam logic [15:0] CDR_UNMAPPED_VALUE = 16'h0000;

    // ========================================================================
    // field layout
    localparam int CDR_DATA_W        = 16;
    localparam int CDR_BOOST_W       = 11;
    localparam int CDR_CODE_W        = 3;
    localparam int CDR_DIM_FREQ_LSB  = 12;
    localparam int CDR_LAYOUT_LSB    = 8;
    localparam int CDR_SW_FREQ_LSB   = 3;
    localparam int CDR_MODE_LSB      = 0;
    localparam logic [15:0] CDR_CONFIG_USED_MASK = 16'h773F;
    localparam logic [15:0] CDR_BOOST_USED_MASK  = 16'h07FF;

    // ========================================================================
    // codes
    localparam logic [2:0] CDR_LAYOUT_SIX_SEPARATE = 3'h0;
    localparam logic [2:0] CDR_LAYOUT_FIVE         = 3'h1;
    localparam logic [2:0] CDR_LAYOUT_FOUR         = 3'h2;
    localparam logic [2:0] CDR_LAYOUT_THREE        = 3'h3;
    localparam logic [2:0] CDR_LAYOUT_TWO          = 3'h4;
    localparam logic [2:0] CDR_LAYOUT_THREE_GROUPS = 3'h5;
    localparam logic [2:0] CDR_LAYOUT_TWO_GROUPS   = 3'h6;
    localparam logic [2:0] CDR_LAYOUT_ONE_GROUP    = 3'h7;
    localparam logic [6:0] CDR_BUS_ADDR_LOW_MODES  = 7'h2B;
    localparam logic [6:0] CDR_BUS_ADDR_HIGH_MODES = 7'h2A;
    localparam int CDR_MODE_ADDR_BIT = 2;

    typedef enum logic [1:0]
    {
        CDR_DIM_PWM,
        CDR_DIM_HYBRID,
        CDR_DIM_CONSTANT,
        CDR_DIM_DIRECT
    } cdr_dim_mode_t;

    // ========================================================================
    // timing
    localparam int CDR_CLK_HZ          = 100_000_000;
    localparam int CDR_DIM_FREQ_MAX_HZ = 19531;
    localparam int CDR_DIM_FREQ_MIN_HZ = 152;
    localparam int CDR_FAST_PERIOD_CYC = CDR_CLK_HZ / CDR_DIM_FREQ_MAX_HZ;
    localparam int CDR_CHANNELS        = 6;
    localparam int CDR_PHASE_DEG       = 60;
    localparam int CDR_CNT_W           = 20;
    localparam int CDR_SLOT_W          = 3;
    localparam logic [2:0] CDR_SLOWEST_CODE = 3'h7;

endpackage

// [hdl/cdr_strap_capture.sv]
// latches the strap detection results once detection reports done
`timescale 1ns/1ps
module cdr_strap_capture
    import cdr_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // detection results
    input  wire logic       detect_done,
    input  wire logic [2:0] dimming_frequency_strap,
    input  wire logic [2:0] string_layout_strap,
    input  wire logic [2:0] switching_frequency_strap,
    input  wire logic [2:0] mode_strap,
    // latched codes
    output logic            detect_loaded,
    output logic [2:0]      detected_dimming_frequency,
    output logic [2:0]      detected_string_layout,
    output logic [2:0]      detected_switching_frequency,
    output logic [2:0]      detected_mode
);

    typedef enum logic
    {
        CDR_WAIT_DETECT,
        CDR_HOLD
    } cdr_cap_state_t;

    cdr_cap_state_t state;
    cdr_cap_state_t next_state;
    logic [11:0]    codes;
    logic [11:0]    next_codes;

    // ========================================================================
    // next values: capture once; later detection pulses cannot disturb the
    // settings the rest of the device was started with
    always_comb
    begin
        next_state = state;
        next_codes = codes;
        case (state)
            CDR_WAIT_DETECT:
            begin
                if (detect_done)
                begin
                    next_codes = {dimming_frequency_strap, string_layout_strap,
                                  switching_frequency_strap, mode_strap};
                    next_state = CDR_HOLD;
                end
            end
            CDR_HOLD:
            begin
                next_state = CDR_HOLD;
            end
            default:
            begin
                next_state = CDR_WAIT_DETECT;
                next_codes = 12'h000;
            end
        endcase
    end

    // ========================================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state <= CDR_WAIT_DETECT;
            codes <= 12'h000;
        end
        else
        begin
            state <= next_state;
            codes <= next_codes;
        end
    end

    assign detect_loaded                = (state == CDR_HOLD);
    assign detected_dimming_frequency   = codes[11:9];
    assign detected_string_layout       = codes[8:6];
    assign detected_switching_frequency = codes[5:3];
    assign detected_mode                = codes[2:0];

endmodule

// [hdl/cdr_phase_spread.sv]
// dimming period timer with evenly spread per-channel start pulses
`timescale 1ns/1ps
module cdr_phase_spread
    import cdr_pkg::*;
#(
    parameter int FAST_PERIOD_CYC = CDR_FAST_PERIOD_CYC
)
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // configuration
    input  wire logic       run,
    input  wire logic       spread,
    input  wire logic [2:0] dim_freq_code,
    // per-channel period starts
    output logic [5:0]      channel_start
);

    logic [CDR_CNT_W-1:0]  slot_len;
    logic [CDR_CNT_W-1:0]  slot_cnt;
    logic [CDR_CNT_W-1:0]  next_slot_cnt;
    logic [CDR_SLOT_W-1:0] slot;
    logic [CDR_SLOT_W-1:0] next_slot;
    logic [5:0]            next_channel_start;
    logic                  slot_end;

    // each code step halves the period; one slot is a sixth of it
    assign slot_len = CDR_CNT_W'((FAST_PERIOD_CYC / CDR_CHANNELS) << (CDR_SLOWEST_CODE - dim_freq_code));
    assign slot_end = (slot_cnt >= slot_len - CDR_CNT_W'(1));

    // ========================================================================
    // next values
    always_comb
    begin
        next_slot_cnt      = slot_cnt;
        next_slot          = slot;
        next_channel_start = 6'h00;
        if (!run)
        begin
            next_slot_cnt = '0;
            next_slot     = '0;
        end
        else if (slot_end)
        begin
            next_slot_cnt = '0;
            next_slot     = (slot == CDR_SLOT_W'(CDR_CHANNELS - 1)) ? '0 : slot + CDR_SLOT_W'(1);
        end
        else
        begin
            next_slot_cnt = slot_cnt + CDR_CNT_W'(1);
        end
        // successive channels start one slot (60 degrees) apart
        if (run && slot_cnt == '0)
        begin
            if (spread)
            begin
                next_channel_start = 6'h01 << slot;
            end
            else if (slot == '0)
            begin
                next_channel_start = 6'h3F;
            end
        end
    end

    // ========================================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            slot_cnt      <= '0;
            slot          <= '0;
            channel_start <= 6'h00;
        end
        else
        begin
            slot_cnt      <= next_slot_cnt;
            slot          <= next_slot;
            channel_start <= next_channel_start;
        end
    end

endmodule

// [dv/cdr_host_model.sv]
// host side model that drives the register port of the readback bank
`timescale 1ns/1ps
module cdr_host_model
(
    // clock
    input  wire logic        sys_clk,
    // register port
    output logic [7:0]       reg_addr,
    output logic             reg_rd,
    output logic             reg_wr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // ========================================================================
    // one access: strobe is a single-cycle pulse, address and data held to the ack
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                          output logic [15:0] rd, output int lat);
        begin
            @(posedge sys_clk);
            #1;
            reg_addr  = addr;
            reg_wdata = wd;
            reg_rd    = ~wr;
            reg_wr    = wr;
            lat       = 0;
            do
            begin
                @(posedge sys_clk);
                #1;
                reg_rd = 1'b0;
                reg_wr = 1'b0;
                lat++;
            end
            while (reg_ack !== 1'b1 && lat < 8);
            rd = reg_rdata;
            @(posedge sys_clk);
            #1;
            // released lines show a changed pattern, so a stale value cannot pass
            reg_addr  = ~addr;
            reg_wdata = ~wd;
        end
    endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the configuration and boost readback bank
`timescale 1ns/1ps
module testbench
    import cdr_pkg::*;
;
    // short period keeps the slowest dimming code affordable
    localparam int FAST = 60;
    logic          sys_clk;
    logic          rst_b;
    logic [7:0]    reg_addr;
    logic          reg_rd;
    logic          reg_wr;
    logic [15:0]   reg_wdata;
    logic [15:0]   reg_rdata;
    logic          reg_ack;
    logic [10:0]   boost_voltage_code;
    logic          detect_done;
    logic [2:0]    dim_s;
    logic [2:0]    lay_s;
    logic [2:0]    sw_s;
    logic [2:0]    mode_s;
    logic [6:0]    bus_address;
    cdr_dim_mode_t dimming_mode;
    logic [2:0]    detected_string_layout;
    logic [2:0]    detected_switching_frequency;
    logic [5:0]    channel_start;
    int            err_count;
    int            total_checks;
    logic [15:0]   cfg;
    logic [10:0]   code;
    logic [5:0]    v;
    logic [5:0]    pv;
    int            cyc;
    int            slot;

    cdr_readback #(.FAST_PERIOD_CYC(FAST)) dut
    (
        .sys_clk, .rst_b, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_ack,
        .boost_voltage_code, .detect_done, .dimming_frequency_strap(dim_s), .string_layout_strap(lay_s),
        .switching_frequency_strap(sw_s), .mode_strap(mode_s), .bus_address, .dimming_mode,
        .detected_string_layout, .detected_switching_frequency, .channel_start
    );

    cdr_host_model host
    (
        .sys_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_ack
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ========================================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        begin
            total_checks++;
            if (seen !== exp)
            begin
                err_count++;
                $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
            end
        end
    endtask

    task automatic final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    function automatic logic [15:0] exp_cfg(input logic [2:0] d, input logic [2:0] l,
                                            input logic [2:0] s, input logic [2:0] m);
        return {1'b0, d, 1'b0, l, 2'b00, s, m};
    endfunction

    task automatic access_chk(input logic wr, input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] got;
        int          lat;
        begin
            host.access(wr, a, 16'($urandom), got, lat);
            check(16'(lat), 16'h0001, "ack latency");
            if (!wr)
                check(got, exp, what);
        end
    endtask

    task automatic do_reset(input int n);
        begin
            @(posedge sys_clk);
            #1;
            rst_b = 1'b0;
            repeat (n) @(posedge sys_clk);
            #1;
            rst_b = 1'b1;
        end
    endtask

    task automatic detect(input logic [11:0] straps);
        begin
            @(posedge sys_clk);
            #1;
            {dim_s, lay_s, sw_s, mode_s} = straps;
            detect_done = 1'b1;
            @(posedge sys_clk);
            #1;
            detect_done = 1'b0;
            {dim_s, lay_s, sw_s, mode_s} = ~straps;
            repeat (2) @(posedge sys_clk);
        end
    endtask

    task automatic next_pulse(output logic [5:0] pulse, output int n);
        begin
            n = 0;
            do
            begin
                @(posedge sys_clk);
                #1;
                n++;
            end
            while (channel_start === 6'h00 && n < 20000);
            pulse = channel_start;
        end
    endtask

    // ========================================================================
    // sequence
    initial
    begin
        rst_b              = 1'b0;
        detect_done        = 1'b0;
        boost_voltage_code = 11'h000;
        {dim_s, lay_s, sw_s, mode_s} = 12'h000;
        err_count          = 0;
        total_checks       = 0;
        cyc                = $urandom(64054);
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check(reg_rdata, 16'h0000, "read data after reset");
        check(16'(bus_address), 16'h002B, "address before detection");
        access_chk(1'b0, 8'h1C, 16'h0000, "boost after reset");
        access_chk(1'b0, 8'h1E, 16'h0000, "config before detection");
        access_chk(1'b0, 8'h1D, 16'h0000, "unmapped read");
        $display("reset test done");

        for (int i = 0; i < 24; i++)
        begin
            code = (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : 11'($urandom);
            @(posedge sys_clk);
            #1;
            boost_voltage_code = code;
            access_chk(1'b0, 8'h1C, {5'h00, code}, "boost code");
            access_chk(1'b1, 8'h1C, 16'h0000, "boost write");
            access_chk(1'b0, 8'h1C, {5'h00, code}, "boost after write");
        end
        $display("boost test done");

        // every code of every field once; each reset gets a detection, then a second one after the write that must be ignored
        for (int i = 0; i < 8; i++)
        begin
            do_reset(2);
            detect({3'(i), 3'(i), 3'((i + 5) % 8), 3'(7 - i)});
            cfg = exp_cfg(3'(i), 3'(i), 3'((i + 5) % 8), 3'(7 - i));
            access_chk(1'b0, 8'h1E, cfg, "config word");
            access_chk(1'b1, 8'h1E, 16'h0000, "config write");
            detect(~cfg[11:0]);
            access_chk(1'b0, 8'h1E, cfg, "config after write");
            check(16'(bus_address), (i < 4) ? 16'h002A : 16'h002B, "bus address");
            check(16'(dimming_mode), 16'(cfg[1:0]), "dimming mode");
            check(16'(detected_string_layout), 16'(i), "string layout");
            check(16'(detected_switching_frequency), 16'(cfg[5:3]), "switching code");
            // slot shrinks by half for each faster dimming code
            slot = (FAST / 6) << (7 - i);
            next_pulse(v, cyc);
            check(16'($countones(v)), (i == 0) ? 16'h0001 : 16'h0006, "first start pattern");
            for (int k = 0; k < ((i == 0) ? 6 : 2); k++)
            begin
                pv = v;
                next_pulse(v, cyc);
                check(16'(cyc), 16'((i == 0) ? slot : 6 * slot), "start spacing");
                check(16'(v), (i == 0) ? 16'({pv[4:0], pv[5]}) : 16'h003F, "start pattern");
            end
            $display("detection test %0d done", i);
        end
        final_report();
    end

    initial
    begin
        #1_000_000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
endmodule
